// ---- verilog/dcw_pkg.sv ----
// Purpose: constants, field positions and carrier types for the configuration word decoder
// Assumes: three 32-bit configuration words are fetched from flash one at a time after reset is released
// Notes: the decoded settings are frozen after the load until the next reset
// How it works
// - window size 11/10/01/00 gives 25, 37.5, 50, 75 percent of timeout.
// - watchdog hard enable 1 forces watchdog on; software cannot disable it.
// - window disable 1 selects non-window mode, 0 selects window mode.
// - postscale ratio is two to the power of the five-bit field.
// - postscale codes above 10100 behave as 10100.
// - switch/monitor 1x none, 01 switching only, 00 switching plus fail-safe.
// - peripheral bus divisor 11/10/01/00 divides system clock by 8/4/2/1.
// - clock out config 0 drives clock out only when primary mode 11 or 00.
// - primary mode 11 off, 10 high speed, 01 standard crystal, 00 external.
// - two-speed start-up enable bit 1 performs two-speed start-up.
// - three-bit reset oscillator select picks one of eight clock sources.
// - system pll output divisor codes give 1,2,4,8,16,32,64,256.
// - usb pll enable_n 1 disables and bypasses the usb pll.
// - usb pll input divider codes give 1,2,3,4,5,6,10,12.
// - system pll multiplier codes give 15 to 21, then 24.
// - bus power pin owner 1 hands that pin to the usb module.
// - usb identifier pin owner 1 hands that pin to the usb module.
// - one-shot bits allow one pin-select or module-disable reconfiguration only.
// - 16-bit user identifier word held and readable by external tools.
// - while pin select lock is set, pin-select register writes are rejected.

package dcw_pkg;

  // ==========================================
  // word indices and word count
  localparam logic [1:0] DCW_WORD_ONE = 2'h1;
  localparam logic [1:0] DCW_WORD_TWO = 2'h2;
  localparam logic [1:0] DCW_WORD_THREE = 2'h3;
  localparam int DCW_WORD_COUNT = 3;

  // ==========================================
  // word one field positions
  localparam int W1_WIN_SIZE_LSB = 24;
  localparam int W1_HARD_EN_BIT = 23;
  localparam int W1_WIN_DIS_BIT = 22;
  localparam int W1_POSTSCALE_LSB = 16;
  localparam int W1_SWITCH_MON_LSB = 14;
  localparam int W1_PB_DIV_LSB = 12;
  localparam int W1_CLKOUT_BIT = 10;
  localparam int W1_POSC_MODE_LSB = 8;
  localparam int W1_TWO_SPEED_BIT = 7;
  localparam int W1_SOSC_EN_BIT = 5;
  localparam int W1_OSC_SEL_LSB = 0;

  // word two field positions
  localparam int W2_PLL_ODIV_LSB = 16;
  localparam int W2_USB_PLL_EN_N_BIT = 15;
  localparam int W2_USB_IDIV_LSB = 8;
  localparam int W2_PLL_MUL_LSB = 4;
  localparam int W2_PLL_IDIV_LSB = 0;

  // word three field positions
  localparam int W3_BUS_POWER_OWN_BIT = 31;
  localparam int W3_USB_ID_OWN_BIT = 30;
  localparam int W3_PIN_ONE_SHOT_BIT = 29;
  localparam int W3_MOD_ONE_SHOT_BIT = 28;
  localparam int W3_USER_ID_LSB = 0;

  // ==========================================
  // decode values
  localparam logic [4:0] DCW_POSTSCALE_MAX = 5'h14;
  localparam logic [1:0] DCW_POSC_OFF = 2'h3;
  localparam logic [1:0] DCW_POSC_EXT = 2'h0;
  // erased flash reads all ones; raw words and stored copy before the load match that
  localparam logic [31:0] DCW_ERASED = 32'hffffffff;

  // window fraction in eighths of the timeout: 2/8, 3/8, 4/8, 6/8
  localparam logic [3:0] DCW_WIN_25 = 4'h2;
  localparam logic [3:0] DCW_WIN_375 = 4'h3;
  localparam logic [3:0] DCW_WIN_50 = 4'h4;
  localparam logic [3:0] DCW_WIN_75 = 4'h6;

  typedef enum logic [2:0] {
    DCW_SRC_FRC = 3'b000,
    DCW_SRC_FAST_RC_PROGRAMMABLE_DIVIDE_PLL = 3'b001,
    DCW_SRC_POSC = 3'b010,
    DCW_SRC_POSC_PLL = 3'b011,
    DCW_SRC_SOSC = 3'b100,
    DCW_SRC_LOW_POWER_RC_OSCILLATOR = 3'b101,
    DCW_SRC_FRC_DIV16 = 3'b110,
    DCW_SRC_FRC_PROG_DIV = 3'b111
  } dcw_osc_src_t;

  typedef enum logic [1:0] {
    DCW_POSC_MODE_EXT = 2'b00,
    DCW_POSC_MODE_XT = 2'b01,
    DCW_POSC_MODE_HS = 2'b10,
    DCW_POSC_MODE_OFF = 2'b11
  } dcw_posc_mode_t;

  typedef enum logic [1:0] {
    DCW_LD_IDLE = 2'b00,
    DCW_LD_REQ = 2'b01,
    DCW_LD_WAIT = 2'b10,
    DCW_LD_DONE = 2'b11
  } dcw_load_state_t;

  // ==========================================
  // carriers
  typedef struct packed {
    logic wdt_force_on;
    logic wdt_window_mode;
    logic [3:0] wdt_window_eighths;
    logic [4:0] wdt_postscale_log2;
    logic clock_switch_enable;
    logic fail_safe_monitor_enable;
    logic [3:0] pb_divisor;
    logic clock_out_enable;
    dcw_posc_mode_t posc_mode;
    logic two_speed_startup;
    logic sosc_enable;
    dcw_osc_src_t reset_osc_src;
  } dcw_clock_cfg_t;

  typedef struct packed {
    logic [8:0] sys_pll_out_div;
    logic usb_pll_enable;
    logic [3:0] usb_pll_in_div;
    logic [4:0] sys_pll_mul;
    logic [3:0] sys_pll_in_div;
  } dcw_pll_cfg_t;

  typedef struct packed {
    logic bus_power_usb_owned;
    logic usb_id_usb_owned;
    logic pin_select_one_shot;
    logic module_disable_one_shot;
    logic [15:0] user_identifier_word;
  } dcw_usb_cfg_t;

endpackage : dcw_pkg

// ---- verilog/dcw_word_store.sv ----
// Purpose: holds the three raw configuration words as loaded from flash
// Assumes: one write port from the loader, one registered read port
// Notes: read data comes out of a register, one cycle after the address

`timescale 1ns/100ps
`default_nettype none

module dcw_word_store
  import dcw_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // write side
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);

  // ==========================================
  // storage
  logic [WIDTH-1:0] mem_q [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_word
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          mem_q[gi] <= WIDTH'(DCW_ERASED);
        end else if (clk_en && wr_en && (wr_addr == 2'(gi))) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_data_q <= WIDTH'(DCW_ERASED);
    end else if (clk_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule : dcw_word_store

`default_nettype wire

// ---- verilog/dcw_pin_lock.sv ----
// Purpose: pin-select and module-disable lock with one-shot limit
// Assumes: unlock sequence is checked elsewhere; lock_wr means a permitted lock write
// Notes: once a one-shot lock has been set it cannot be cleared before reset

`timescale 1ns/100ps
`default_nettype none

module dcw_pin_lock (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // configuration
  input wire logic one_shot,
  input wire logic cfg_valid,
  // lock control
  input wire logic lock_wr,
  input wire logic lock_wdata,
  // state
  output logic lock_q,
  output logic used_q
);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lock_q <= 1'b0;
      used_q <= 1'b0;
    end else if (clk_en && cfg_valid && lock_wr) begin
      // a one-shot lock that was set once stays set: one reconfiguration only
      if (!(one_shot && used_q)) begin
        lock_q <= lock_wdata;
        used_q <= used_q | lock_wdata;
      end
    end
  end

endmodule : dcw_pin_lock

`default_nettype wire

// ---- verilog/dcw_decoder.sv ----
// Purpose: loads three configuration words from flash at reset and decodes them
// Assumes: flash answers each read with flash_rd_valid some cycles after flash_rd_req
// Notes: settings read all zeros until cfg_valid_q rises, then hold until reset

`timescale 1ns/100ps
`default_nettype none

module dcw_decoder
  import dcw_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // flash fetch
  output logic flash_rd_req_q,
  output logic [1:0] flash_rd_word_q,
  input wire logic flash_rd_valid,
  input wire logic [31:0] flash_rd_data,
  // programming port read of stored words
  input wire logic [1:0] prog_rd_word,
  output logic [31:0] prog_rd_data_q,
  output logic [15:0] user_identifier_word_q,
  // run-time lock and watchdog software control
  input wire logic pin_select_lock_wr,
  input wire logic pin_select_lock_wdata,
  input wire logic module_disable_lock_wr,
  input wire logic module_disable_lock_wdata,
  input wire logic sw_watchdog_on,
  input wire logic pps_wr_req,
  // decoded settings
  output logic cfg_valid_q,
  output dcw_clock_cfg_t clock_cfg_q,
  output dcw_pll_cfg_t pll_cfg_q,
  output dcw_usb_cfg_t usb_cfg_q,
  output logic watchdog_run_q,
  output logic pin_select_lock_q,
  output logic module_disable_lock_q,
  output logic pps_wr_accept_q,
  output logic clock_out_on_pin_q
);

  // ==========================================
  // divider decode shared by both pll input dividers
  function automatic logic [3:0] pll_in_div(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h1;
    unique case (code)
      3'b000: r = 4'h1;
      3'b001: r = 4'h2;
      3'b010: r = 4'h3;
      3'b011: r = 4'h4;
      3'b100: r = 4'h5;
      3'b101: r = 4'h6;
      3'b110: r = 4'ha;
      3'b111: r = 4'hc;
    endcase
    return r;
  endfunction : pll_in_div

  function automatic logic [8:0] pll_out_div(input logic [2:0] code);
    logic [8:0] r;
    // 111 is 256, not 128: the series breaks at the top code
    r = (code == 3'b111) ? 9'h100 : 9'(9'h1 << code);
    return r;
  endfunction : pll_out_div

  function automatic logic [4:0] pll_mul(input logic [2:0] code);
    logic [4:0] r;
    r = (code == 3'b111) ? 5'h18 : 5'(5'hf + {2'h0, code});
    return r;
  endfunction : pll_mul

  function automatic logic [3:0] win_eighths(input logic [1:0] code);
    logic [3:0] r;
    r = DCW_WIN_75;
    unique case (code)
      2'b11: r = DCW_WIN_25;
      2'b10: r = DCW_WIN_375;
      2'b01: r = DCW_WIN_50;
      2'b00: r = DCW_WIN_75;
    endcase
    return r;
  endfunction : win_eighths

  // ==========================================
  // loader state
  dcw_load_state_t ld_state_q, ld_state_d;
  logic [1:0] ld_word_q;
  logic [31:0] word_one_q, word_two_q, word_three_q;
  logic store_wr;

  assign store_wr = (ld_state_q == DCW_LD_WAIT) && flash_rd_valid;

  always_comb begin
    ld_state_d = ld_state_q;
    unique case (ld_state_q)
      DCW_LD_IDLE: ld_state_d = DCW_LD_REQ;
      DCW_LD_REQ: ld_state_d = DCW_LD_WAIT;
      DCW_LD_WAIT: begin
        if (flash_rd_valid) begin
          ld_state_d = (ld_word_q == DCW_WORD_THREE) ? DCW_LD_DONE : DCW_LD_REQ;
        end
      end
      DCW_LD_DONE: ld_state_d = DCW_LD_DONE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ld_state_q <= DCW_LD_IDLE;
    end else if (clk_en) begin
      ld_state_q <= ld_state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ld_word_q <= DCW_WORD_ONE;
    end else if (clk_en && store_wr && ld_word_q != DCW_WORD_THREE) begin
      ld_word_q <= 2'(ld_word_q + 2'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flash_rd_req_q <= 1'b0;
      flash_rd_word_q <= DCW_WORD_ONE;
    end else if (clk_en) begin
      flash_rd_req_q <= (ld_state_d == DCW_LD_REQ);
      flash_rd_word_q <= store_wr && ld_word_q != DCW_WORD_THREE
                         ? 2'(ld_word_q + 2'h1) : ld_word_q;
    end
  end

  // raw words are captured only during the load, never afterwards
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      word_one_q <= DCW_ERASED;
      word_two_q <= DCW_ERASED;
      word_three_q <= DCW_ERASED;
    end else if (clk_en && store_wr) begin
      if (ld_word_q == DCW_WORD_ONE) begin
        word_one_q <= flash_rd_data;
      end
      if (ld_word_q == DCW_WORD_TWO) begin
        word_two_q <= flash_rd_data;
      end
      if (ld_word_q == DCW_WORD_THREE) begin
        word_three_q <= flash_rd_data;
      end
    end
  end

  // ==========================================
  // stored copy for the programming port
  dcw_word_store #(
    .WIDTH(32),
    .DEPTH(4)
  ) u_store (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr_en(store_wr),
    .wr_addr(ld_word_q),
    .wr_data(flash_rd_data),
    .rd_addr(prog_rd_word),
    .rd_data_q(prog_rd_data_q)
  );

  // ==========================================
  // field decode
  dcw_clock_cfg_t clock_d;
  dcw_pll_cfg_t pll_d;
  dcw_usb_cfg_t usb_d;
  logic [4:0] ps_code;
  logic [1:0] sm_code;

  always_comb begin
    ps_code = word_one_q[W1_POSTSCALE_LSB +: 5];
    sm_code = word_one_q[W1_SWITCH_MON_LSB +: 2];
    clock_d.wdt_force_on = word_one_q[W1_HARD_EN_BIT];
    clock_d.wdt_window_mode = !word_one_q[W1_WIN_DIS_BIT];
    clock_d.wdt_window_eighths = win_eighths(word_one_q[W1_WIN_SIZE_LSB +: 2]);
    clock_d.wdt_postscale_log2 = (ps_code > DCW_POSTSCALE_MAX) ? DCW_POSTSCALE_MAX : ps_code;
    clock_d.clock_switch_enable = !sm_code[1];
    clock_d.fail_safe_monitor_enable = (sm_code == 2'b00);
    clock_d.pb_divisor = 4'(4'h1 << word_one_q[W1_PB_DIV_LSB +: 2]);
    clock_d.posc_mode = dcw_posc_mode_t'(word_one_q[W1_POSC_MODE_LSB +: 2]);
    // clock out is only meaningful when the oscillator pin is free
    clock_d.clock_out_enable = !word_one_q[W1_CLKOUT_BIT] &&
      (word_one_q[W1_POSC_MODE_LSB +: 2] == DCW_POSC_OFF ||
       word_one_q[W1_POSC_MODE_LSB +: 2] == DCW_POSC_EXT);
    clock_d.two_speed_startup = word_one_q[W1_TWO_SPEED_BIT];
    clock_d.sosc_enable = word_one_q[W1_SOSC_EN_BIT];
    // no guard against primary off with primary selected; that is the programmer's duty
    clock_d.reset_osc_src = dcw_osc_src_t'(word_one_q[W1_OSC_SEL_LSB +: 3]);

    pll_d.sys_pll_out_div = pll_out_div(word_two_q[W2_PLL_ODIV_LSB +: 3]);
    pll_d.usb_pll_enable = !word_two_q[W2_USB_PLL_EN_N_BIT];
    pll_d.usb_pll_in_div = pll_in_div(word_two_q[W2_USB_IDIV_LSB +: 3]);
    pll_d.sys_pll_mul = pll_mul(word_two_q[W2_PLL_MUL_LSB +: 3]);
    pll_d.sys_pll_in_div = pll_in_div(word_two_q[W2_PLL_IDIV_LSB +: 3]);

    usb_d.bus_power_usb_owned = word_three_q[W3_BUS_POWER_OWN_BIT];
    usb_d.usb_id_usb_owned = word_three_q[W3_USB_ID_OWN_BIT];
    usb_d.pin_select_one_shot = word_three_q[W3_PIN_ONE_SHOT_BIT];
    usb_d.module_disable_one_shot = word_three_q[W3_MOD_ONE_SHOT_BIT];
    usb_d.user_identifier_word = word_three_q[W3_USER_ID_LSB +: 16];
  end

  // ==========================================
  // decoded outputs, latched once when the load completes
  logic load_done;
  assign load_done = (ld_state_q == DCW_LD_DONE);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg_valid_q <= 1'b0;
    end else if (clk_en && load_done) begin
      cfg_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clock_cfg_q <= '0;
      pll_cfg_q <= '0;
      usb_cfg_q <= '0;
      user_identifier_word_q <= 16'h0;
      clock_out_on_pin_q <= 1'b0;
    end else if (clk_en && load_done && !cfg_valid_q) begin
      clock_cfg_q <= clock_d;
      pll_cfg_q <= pll_d;
      usb_cfg_q <= usb_d;
      user_identifier_word_q <= usb_d.user_identifier_word;
      clock_out_on_pin_q <= clock_d.clock_out_enable;
    end
  end

  // ==========================================
  // watchdog run: forced on by configuration, else follows software
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      watchdog_run_q <= 1'b0;
    end else if (clk_en && cfg_valid_q) begin
      watchdog_run_q <= clock_cfg_q.wdt_force_on | sw_watchdog_on;
    end
  end

  // ==========================================
  // locks
  logic pin_lock, mod_lock;

  dcw_pin_lock u_pin_lock (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .one_shot(usb_cfg_q.pin_select_one_shot),
    .cfg_valid(cfg_valid_q),
    .lock_wr(pin_select_lock_wr),
    .lock_wdata(pin_select_lock_wdata),
    .lock_q(pin_lock),
    .used_q()
  );

  dcw_pin_lock u_mod_lock (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .one_shot(usb_cfg_q.module_disable_one_shot),
    .cfg_valid(cfg_valid_q),
    .lock_wr(module_disable_lock_wr),
    .lock_wdata(module_disable_lock_wdata),
    .lock_q(mod_lock),
    .used_q()
  );

  assign pin_select_lock_q = pin_lock;
  assign module_disable_lock_q = mod_lock;

  // a pin-select write is accepted only while unlocked; one cycle later
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pps_wr_accept_q <= 1'b0;
    end else if (clk_en) begin
      pps_wr_accept_q <= pps_wr_req && !pin_lock;
    end
  end

endmodule : dcw_decoder

`default_nettype wire

// ---- bench/dcw_decoder_chk.sv ----
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: frozen cycles (clk_en low) are left out of the watchdog and pin-select write checks
`timescale 1ns/100ps
`default_nettype none

module dcw_decoder_chk
  import dcw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // requests
  input wire logic flash_rd_req_q,
  input wire logic sw_watchdog_on,
  input wire logic pps_wr_req,
  // settings
  input wire logic cfg_valid_q,
  input wire dcw_clock_cfg_t clock_cfg_q,
  input wire dcw_pll_cfg_t pll_cfg_q,
  input wire dcw_usb_cfg_t usb_cfg_q,
  input wire logic [15:0] user_identifier_word_q,
  input wire logic watchdog_run_q,
  input wire logic pin_select_lock_q,
  input wire logic module_disable_lock_q,
  input wire logic pps_wr_accept_q,
  input wire logic clock_out_on_pin_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // ====================
  // load and freeze
  AST_REQ_PULSE: assert property (flash_rd_req_q |=> !flash_rd_req_q)
    else $error("fetch pulse too long");
  AST_NO_FETCH_AFTER_LOAD: assert property (cfg_valid_q |-> !flash_rd_req_q)
    else $error("fetch after load");
  AST_FROZEN: assert property (cfg_valid_q |=> cfg_valid_q && $stable(clock_cfg_q)
    && $stable(pll_cfg_q) && $stable(usb_cfg_q)) else $error("settings changed");

  // ====================
  // decoded fields
  AST_CLOCK_OUT: assert property (cfg_valid_q |-> clock_out_on_pin_q ==
    (clock_cfg_q.clock_out_enable && clock_cfg_q.posc_mode inside {DCW_POSC_MODE_OFF,
    DCW_POSC_MODE_EXT})) else $error("clock out gating");
  AST_MONITOR: assert property (clock_cfg_q.fail_safe_monitor_enable |->
    clock_cfg_q.clock_switch_enable) else $error("monitor without switching");
  AST_POSTSCALE: assert property (cfg_valid_q |-> clock_cfg_q.wdt_postscale_log2 <= 5'h14)
    else $error("postscale above max");
  AST_USER_ID: assert property (cfg_valid_q |=> user_identifier_word_q ==
    usb_cfg_q.user_identifier_word) else $error("user identifier");

  // ====================
  // run-time control
  AST_WATCHDOG: assert property (cfg_valid_q && clk_en |=> watchdog_run_q ==
    ($past(clock_cfg_q.wdt_force_on) || $past(sw_watchdog_on))) else $error("watchdog run");
  AST_PPS: assert property (cfg_valid_q && clk_en |=> pps_wr_accept_q ==
    ($past(pps_wr_req) && !$past(pin_select_lock_q))) else $error("pin-select write gate");
  AST_PIN_ONE_SHOT: assert property (usb_cfg_q.pin_select_one_shot && pin_select_lock_q
    |=> pin_select_lock_q) else $error("pin lock cleared");
  AST_MOD_ONE_SHOT: assert property (usb_cfg_q.module_disable_one_shot
    && module_disable_lock_q |=> module_disable_lock_q) else $error("module lock cleared");
endmodule : dcw_decoder_chk

bind dcw_decoder dcw_decoder_chk i_chk (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
  .flash_rd_req_q(flash_rd_req_q), .sw_watchdog_on(sw_watchdog_on), .pps_wr_req(pps_wr_req),
  .cfg_valid_q(cfg_valid_q), .clock_cfg_q(clock_cfg_q), .pll_cfg_q(pll_cfg_q),
  .usb_cfg_q(usb_cfg_q), .user_identifier_word_q(user_identifier_word_q),
  .watchdog_run_q(watchdog_run_q), .pin_select_lock_q(pin_select_lock_q),
  .module_disable_lock_q(module_disable_lock_q), .pps_wr_accept_q(pps_wr_accept_q),
  .clock_out_on_pin_q(clock_out_on_pin_q));

`default_nettype wire

// ---- bench/dcw_flash_model.sv ----
// Purpose: behavioural flash answering word fetches
// Assumes: one outstanding fetch; lat is at least 2
// Notes: idle data toggles so stale words never look valid
`timescale 1ns/100ps
`default_nettype none

module dcw_flash_model (
  // clock
  input wire logic core_clk,
  // fetch request
  input wire logic rd_req,
  input wire logic [1:0] rd_word,
  // behaviour control
  input wire logic [3:0] lat,
  input wire logic stray,
  input wire logic [3:1][31:0] words,
  // answer
  output logic rd_valid,
  output logic [31:0] rd_data
);
  logic [3:0] cnt_q = 4'h0;

  // ====================
  // answer after lat cycles
  always_ff @(posedge core_clk) begin
    rd_valid <= stray;
    rd_data <= stray ? 32'h0 : ~rd_data;
    if (rd_req) begin
      cnt_q <= lat;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        rd_valid <= 1'b1;
        rd_data <= words[rd_word];
      end
    end
  end
endmodule : dcw_flash_model

`default_nettype wire

// ---- bench/device_config_word_decoder_bench.sv ----
// Purpose: self-checking bench for the decoder
// Assumes: flash model answers fast or slow by row
// Notes: each row reloads the words through a full reset
`timescale 1ns/100ps
`default_nettype none

module device_config_word_decoder_bench;
  import dcw_pkg::*;

  logic core_clk, resetn, clk_en, rd_valid, stray, sw_watchdog_on, pps_wr_req;
  logic pin_select_lock_wr, pin_select_lock_wdata, module_disable_lock_wr;
  logic module_disable_lock_wdata, flash_rd_req_q, cfg_valid_q, watchdog_run_q;
  logic pin_select_lock_q, module_disable_lock_q, pps_wr_accept_q, clock_out_on_pin_q;
  logic [1:0] flash_rd_word_q, prog_rd_word;
  logic [31:0] rd_data, prog_rd_data_q;
  logic [15:0] user_identifier_word_q;
  logic [3:0] lat;
  logic [3:1][31:0] words, rows [8];
  dcw_clock_cfg_t clock_cfg_q;
  dcw_pll_cfg_t pll_cfg_q;
  dcw_usb_cfg_t usb_cfg_q;
  int err_count, cmp_count;

  dcw_decoder i_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .flash_rd_req_q(flash_rd_req_q), .flash_rd_word_q(flash_rd_word_q),
    .flash_rd_valid(rd_valid), .flash_rd_data(rd_data), .prog_rd_word(prog_rd_word),
    .prog_rd_data_q(prog_rd_data_q), .user_identifier_word_q(user_identifier_word_q),
    .pin_select_lock_wr(pin_select_lock_wr), .pin_select_lock_wdata(pin_select_lock_wdata),
    .module_disable_lock_wr(module_disable_lock_wr),
    .module_disable_lock_wdata(module_disable_lock_wdata), .sw_watchdog_on(sw_watchdog_on),
    .pps_wr_req(pps_wr_req), .cfg_valid_q(cfg_valid_q), .clock_cfg_q(clock_cfg_q),
    .pll_cfg_q(pll_cfg_q), .usb_cfg_q(usb_cfg_q), .watchdog_run_q(watchdog_run_q),
    .pin_select_lock_q(pin_select_lock_q), .module_disable_lock_q(module_disable_lock_q),
    .pps_wr_accept_q(pps_wr_accept_q), .clock_out_on_pin_q(clock_out_on_pin_q));

  dcw_flash_model i_flash (.core_clk(core_clk), .rd_req(flash_rd_req_q),
    .rd_word(flash_rd_word_q), .lat(lat), .stray(stray), .words(words),
    .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ====================
  // expected settings
  function automatic dcw_clock_cfg_t exp_clk(input logic [31:0] w);
    logic [3:0] win [4] = '{4'h6, 4'h4, 4'h3, 4'h2};
    dcw_clock_cfg_t e;
    e.wdt_force_on = w[23];
    e.wdt_window_mode = ~w[22];
    e.wdt_window_eighths = win[w[25:24]];
    e.wdt_postscale_log2 = (w[20:16] > 5'h14) ? 5'h14 : w[20:16];
    e.clock_switch_enable = ~w[15];
    e.fail_safe_monitor_enable = (w[15:14] == 2'h0);
    e.pb_divisor = 4'h1 << w[13:12];
    e.clock_out_enable = ~w[10] & (w[9] == w[8]);
    e.posc_mode = dcw_posc_mode_t'(w[9:8]);
    e.two_speed_startup = w[7];
    e.sosc_enable = w[5];
    e.reset_osc_src = dcw_osc_src_t'(w[2:0]);
    return e;
  endfunction : exp_clk

  function automatic dcw_pll_cfg_t exp_pll(input logic [31:0] w);
    logic [3:0] idiv [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};
    dcw_pll_cfg_t e;
    e.sys_pll_out_div = (w[18:16] == 3'h7) ? 9'h100 : 9'h1 << w[18:16];
    e.usb_pll_enable = ~w[15];
    e.usb_pll_in_div = idiv[w[10:8]];
    e.sys_pll_mul = (w[6:4] == 3'h7) ? 5'h18 : 5'hf + {2'h0, w[6:4]};
    e.sys_pll_in_div = idiv[w[2:0]];
    return e;
  endfunction : exp_pll

  // ====================
  // helpers
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic load(input int hold);
    int n;
    resetn = 1'b0;
    step(20);
    check(cfg_valid_q === 1'b0 && flash_rd_word_q === 2'h1 && prog_rd_data_q === '1,
      "reset values");
    resetn = 1'b1;
    if (hold > 0) begin
      clk_en = 1'b0;
      step(hold);
      check(flash_rd_req_q === 1'b0, "frozen");
      clk_en = 1'b1;
    end
    for (n = 0; n < 200 && cfg_valid_q !== 1'b1; n++) step(1);
    if (cfg_valid_q !== 1'b1) begin
      check(1'b0, "load timeout");
      stop_test();
    end
  endtask : load

  task automatic lock_wr(input logic pin, input logic val);
    pin_select_lock_wdata = val;
    module_disable_lock_wdata = val;
    pin_select_lock_wr = pin;
    module_disable_lock_wr = !pin;
    step(1);
    {pin_select_lock_wr, module_disable_lock_wr} = 2'h0;
  endtask : lock_wr

  task automatic pps_try(input logic exp);
    pps_wr_req = 1'b1;
    step(1);
    pps_wr_req = 1'b0;
    check(pps_wr_accept_q === exp, "pin-select write");
  endtask : pps_try

  // ====================
  // main sequence
  initial begin
    int r, k;
    logic [2:0] i;
    dcw_clock_cfg_t ec;
    {resetn, clk_en, stray, sw_watchdog_on, pps_wr_req, pin_select_lock_wr, pin_select_lock_wdata,
      module_disable_lock_wr, module_disable_lock_wdata} = 9'h080;
    prog_rd_word = 2'h0;
    lat = 4'h2;
    words = '1;
    err_count = 0;
    cmp_count = 0;
    // primary mode is never off while a primary source is chosen
    for (r = 0; r < 8; r++) begin
      i = r[2:0];
      rows[r][1] = {6'h3f, i[1:0], i[0], i[1], 1'b1, i, 2'h0, i[1:0], i[2:1], 1'b1, i[2],
        ~i[1:0], i[0], 1'b1, i[1], 2'h3, i};
      rows[r][2] = {13'h1fff, i, i[0], 4'hf, i, 1'b1, i, 1'b1, i};
      rows[r][3] = {i[0], i[1], i[2], ~i[0], 12'hfff, 13'h0a50, i};
    end
    for (r = 0; r < 8; r++) begin
      words = rows[r];
      lat = r[0] ? 4'h7 : 4'h2;
      load(r == 3 ? 5 : 0);
      ec = exp_clk(words[1]);
      check(clock_cfg_q[24:8] === ec[24:8], "wdt");
      check(clock_cfg_q[7:0] === ec[7:0], "osc");
      check(clock_out_on_pin_q === ec.clock_out_enable, "clock out pin");
      check(pll_cfg_q === exp_pll(words[2]), "pll");
      check(usb_cfg_q === {words[3][31:28], words[3][15:0]}, "usb");
      check(user_identifier_word_q === words[3][15:0], "user id");
      for (k = 0; k < 4; k++) begin
        prog_rd_word = k[1:0];
        step(1);
        check(prog_rd_data_q === (k == 0 ? '1 : words[k]), "stored");
      end
      step(1);
      check(watchdog_run_q === words[1][23], "watchdog alone");
      sw_watchdog_on = 1'b1;
      step(2);
      check(watchdog_run_q === 1'b1, "watchdog on");
      sw_watchdog_on = 1'b0;
      lock_wr(1'b1, 1'b1);
      check(pin_select_lock_q === 1'b1, "pin lock set");
      pps_try(1'b0);
      lock_wr(1'b1, 1'b0);
      check(pin_select_lock_q === words[3][29], "pin lock clear");
      pps_try(!words[3][29]);
      lock_wr(1'b0, 1'b1);
      step(1);
      lock_wr(1'b0, 1'b0);
      check(module_disable_lock_q === words[3][28], "module lock clear");
      check(watchdog_run_q === words[1][23], "watchdog off");
    end
    // stray flash data after the load must not reach the settings
    stray = 1'b1;
    words = ~words;
    step(1);
    stray = 1'b0;
    prog_rd_word = 2'h1;
    step(3);
    check(clock_cfg_q === exp_clk(rows[7][1]) && pll_cfg_q === exp_pll(rows[7][2]),
      "stray settings");
    check(prog_rd_data_q === rows[7][1], "stray word");
    stop_test();
  end
endmodule : device_config_word_decoder_bench

`default_nettype wire
